// file: inc/irm_defines.svh
`ifndef IRM_DEFINES_SVH
`define IRM_DEFINES_SVH

// Number of receive contexts and the spacing between their register sets.
`define IRM_NUM_CTX        4
`define IRM_CTX_STRIDE     16'h0020

// Byte offsets of context 0 registers; context n adds n times the stride.
`define IRM_PTR_BASE       16'h040c
`define IRM_MATCH_BASE     16'h410c

// Field positions inside the match register.
`define IRM_TAG00_BIT      28
`define IRM_TAG01_BIT      29
`define IRM_TAG10_BIT      30
`define IRM_TAG11_BIT      31
`define IRM_CYC_HI         26
`define IRM_CYC_LO         12
`define IRM_SYNC_HI        11
`define IRM_SYNC_LO        8
`define IRM_UPPER_FILT_BIT 6
`define IRM_CHAN_HI        5
`define IRM_CHAN_LO        0

// Writable bits of the match register; bits 27 and 7 stay zero.
`define IRM_MATCH_WMASK    32'hf7ffff7f

// Reset values of the stored registers.
`define IRM_MATCH_RESET    32'h00000000
`define IRM_PTR_RESET      32'h00000000

// Wait selector code that arms the sync compare.
`define IRM_WAIT_SYNC      2'h3

// Width of a buffered word: context number plus packet header word.
`define IRM_BUF_W          34

`endif

// file: inc/irm_pkg.sv
package irm_pkg;

  // Whole state of the match block, registered as one word.
  typedef struct packed {
    logic [3:0][31:0] ptr;      // Descriptor start pointers.
    logic [3:0][31:0] match;    // Packet filter settings.
    logic [3:0]       started;  // Context is past its start condition.
    logic [31:0]      rdata;    // Read data held for the bus.
    logic             rvalid;   // Read data valid pulse.
    logic             rd_match; // Last read hit a filter register.
  } irm_state_t;

  // State of the two-entry buffer.
  typedef struct packed {
    logic [1:0][33:0] slot;     // Two stored words.
    logic             rd_ptr;   // Slot to drain next.
    logic             wr_ptr;   // Slot to fill next.
    logic [1:0]       cnt;      // Number of words held.
  } irm_buf_state_t;

endpackage

// file: verilog/irm_buf.sv
`timescale 1ns/100ps
`include "irm_defines.svh"

// Two-entry buffer so a stall downstream loses no accepted word.
module irm_buf (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Filling side.
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire logic [`IRM_BUF_W-1:0] in_data,
  // Draining side.
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output logic [`IRM_BUF_W-1:0]      out_data
);

  irm_pkg::irm_buf_state_t st;      // Registered state.
  irm_pkg::irm_buf_state_t next_st; // Next state.
  logic                    push;    // Word enters this cycle.
  logic                    pop;     // Word leaves this cycle.

  ////////////////////////////////////////////////////////////////////////////

  // Full and empty come straight from the count, so they are honest.
  assign in_ready  = (st.cnt != 2'h2);
  assign out_valid = (st.cnt != 2'h0);
  assign out_data  = st.slot[st.rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Next state of slots, pointers and count.
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.slot[st.wr_ptr] = in_data;
      next_st.wr_ptr          = ~st.wr_ptr;
    end
    if (pop) begin
      next_st.rd_ptr = ~st.rd_ptr;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 2'h1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 2'h1;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// file: verilog/irm_match.sv
`timescale 1ns/100ps
`include "irm_defines.svh"

module irm_match (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register access.
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  // Context control bits and descriptor state.
  input  wire logic [3:0]  run,
  input  wire logic [3:0]  start_on_cycle_enable,
  input  wire logic [3:0]  all_channels_mask_mode,
  input  wire logic [7:0]  wait_select,
  input  wire logic [63:0] channel_mask,
  input  wire logic [3:0]  ptr_load,
  input  wire logic [31:0] ptr_value,
  // Cycle timer.
  input  wire logic [6:0]  timer_seconds_count,
  input  wire logic [12:0] timer_cycle_count,
  // Received packet headers from the link.
  input  wire logic        pkt_valid,
  output logic             pkt_ready,
  input  wire logic [1:0]  pkt_tag,
  input  wire logic [5:0]  pkt_chan,
  input  wire logic [3:0]  pkt_sync,
  input  wire logic [31:0] pkt_header,
  // Accepted packets toward the context buffers.
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [1:0]       out_ctx,
  output logic [31:0]      out_header
);

  irm_pkg::irm_state_t st;       // Registered state.
  irm_pkg::irm_state_t next_st;  // Next state.
  logic [3:0]          cand;     // Contexts that accept the current packet.
  logic                hit;      // Some context accepts the packet.
  logic [1:0]          ctx;      // Lowest accepting context.
  logic                push;     // Accepted packet is offered to the buffer.
  logic [14:0]         cyc_key;  // Low seconds bits joined with cycle count.
  logic [33:0]         buf_out;  // Buffered context and header.

  ////////////////////////////////////////////////////////////////////////////

  // Decode an address against a base; returns hit flag and context number.
  function automatic logic [2:0] ctx_decode(input logic [15:0] addr, input logic [15:0] base);
    logic [15:0] d;
    d = addr - base;
    ctx_decode = {(addr >= base) && (d[4:0] == 5'h00) && (d[15:7] == 9'h000), d[6:5]};
  endfunction

  // Decide whether one context takes the current packet.
  function automatic logic ctx_accepts(input logic [31:0] m, input logic amm, input logic [1:0] ws);
    logic tag_ok;
    logic chan_ok;
    logic sync_ok;
    tag_ok = m[`IRM_TAG00_BIT + pkt_tag];
    if (pkt_tag == 2'h1 && m[`IRM_UPPER_FILT_BIT] && m[`IRM_TAG01_BIT]) begin
      tag_ok = (pkt_sync[3:2] == 2'h0);
    end // Any other tag, or the filter clear, keeps the plain enable.
    chan_ok = amm ? channel_mask[pkt_chan] : (pkt_chan == m[`IRM_CHAN_HI:`IRM_CHAN_LO]);
    sync_ok = (ws != `IRM_WAIT_SYNC) || (pkt_sync == m[`IRM_SYNC_HI:`IRM_SYNC_LO]);
    ctx_accepts = tag_ok & chan_ok & sync_ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  assign cyc_key = {timer_seconds_count[1:0], timer_cycle_count};

  // Per-context candidates; the lowest numbered context wins a shared packet.
  always_comb begin
    cand = 4'h0;
    ctx  = 2'h0;
    for (int n = 3; n >= 0; n--) begin
      cand[n] = st.started[n] & ctx_accepts(st.match[n], all_channels_mask_mode[n], wait_select[2*n +: 2]);
      if (cand[n]) begin
        ctx = n[1:0];
      end
    end
  end

  assign hit  = |cand;
  // Rejected packets are consumed but never pushed.
  assign push = pkt_valid & hit;

  // Register file, start tracking and read data.
  always_comb begin
    logic [2:0] wdec;
    logic [2:0] mdec;
    logic [2:0] pdec;
    wdec           = ctx_decode(reg_addr, `IRM_MATCH_BASE);
    mdec           = wdec;
    pdec           = ctx_decode(reg_addr, `IRM_PTR_BASE);
    next_st        = st;
    next_st.rvalid = reg_rd;
    next_st.rd_match = reg_rd & mdec[2];
    // Writes store only the writable bits of the match register.
    if (reg_wr && wdec[2]) begin
      next_st.match[wdec[1:0]] = reg_wdata & `IRM_MATCH_WMASK;
    end
    // The pointer is loaded by descriptor logic, never by a bus write.
    for (int n = 0; n < 4; n++) begin
      if (ptr_load[n]) begin
        next_st.ptr[n] = ptr_value;
      end
      // Run is owned by software; the context starts at once or on the cycle match.
      next_st.started[n] = run[n] & (st.started[n] | ~start_on_cycle_enable[n] |
                           (cyc_key == st.match[n][`IRM_CYC_HI:`IRM_CYC_LO]));
    end
    // Reads answer one cycle later; unmapped addresses read zero.
    if (reg_rd) begin
      if (pdec[2]) begin
        next_st.rdata = st.ptr[pdec[1:0]];
      end else if (mdec[2]) begin
        next_st.rdata = st.match[mdec[1:0]];
      end else begin
        next_st.rdata = 32'h00000000;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata  = st.rdata;
  assign reg_rvalid = st.rvalid;

  ////////////////////////////////////////////////////////////////////////////

  // Two-entry buffer between the filter and the context buffers.
  irm_buf u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (pkt_ready),
    .in_data   ({ctx, pkt_header}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (buf_out)
  );

  assign out_ctx    = buf_out[33:32];
  assign out_header = buf_out[31:0];

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // A read of context 0's pointer while no load of it is under way.
  sequence ptr0_read_s;
    reg_rd && reg_addr == `IRM_PTR_BASE && !ptr_load[0];
  endsequence

  ptr_read_a: assert property (ptr0_read_s |=> reg_rvalid && reg_rdata == $past(st.ptr[0]))
    else $error("pointer read wrong");
  ctx_stride_a: assert property (reg_rd && reg_addr == 16'h046c |=> reg_rdata == st.ptr[3] || $past(ptr_load[3]))
    else $error("context 3 pointer not at stride");
  tag_enable_a: assert property (hit |-> st.match[ctx][`IRM_TAG00_BIT + pkt_tag])
    else $error("disabled tag accepted");
  reserved_zero_a: assert property (reg_rvalid && st.rd_match |-> !reg_rdata[27] && !reg_rdata[7])
    else $error("reserved match bit set");
  start_cycle_a: assert property ($rose(st.started[0]) && $past(start_on_cycle_enable[0]) |->
    $past(cyc_key) == $past(st.match[0][`IRM_CYC_HI:`IRM_CYC_LO])) else $error("started off the cycle");
  sync_compare_a: assert property (hit && wait_select[2*ctx +: 2] == `IRM_WAIT_SYNC |->
    pkt_sync == st.match[ctx][`IRM_SYNC_HI:`IRM_SYNC_LO]) else $error("sync mismatch accepted");
  tag01_filter_a: assert property (hit && pkt_tag == 2'h1 && st.match[ctx][`IRM_UPPER_FILT_BIT] |->
    pkt_sync[3:2] == 2'h0) else $error("tag 01 sync filter bypassed");
  other_tags_a: assert property (pkt_valid && st.started[0] && pkt_tag != 2'h1 &&
    st.match[0][`IRM_TAG00_BIT + pkt_tag] && pkt_chan == st.match[0][5:0] && !all_channels_mask_mode[0] &&
    wait_select[1:0] != `IRM_WAIT_SYNC |-> cand[0])
    else $error("other tag wrongly filtered");
  filter_off_a: assert property (pkt_valid && st.started[0] && pkt_tag == 2'h1 &&
    !st.match[0][6] && st.match[0][29] && pkt_chan == st.match[0][5:0] && !all_channels_mask_mode[0] &&
    wait_select[1:0] != `IRM_WAIT_SYNC |-> cand[0])
    else $error("tag 01 restricted with filter off");
  chan_select_a: assert property (hit && !all_channels_mask_mode[ctx] |-> pkt_chan == st.match[ctx][5:0])
    else $error("wrong channel accepted");
  mask_mode_a: assert property (hit && all_channels_mask_mode[ctx] |-> channel_mask[pkt_chan])
    else $error("masked channel accepted");
  no_deliver_a: assert property (pkt_valid && !hit && !out_valid |=> !out_valid)
    else $error("rejected packet delivered");

endmodule

// file: sim/irm_link.sv
`timescale 1ns/100ps

// Link model: offers one packet header at a time and holds it until taken.
module irm_link (
  // Clock.
  input  wire logic   clk,
  // Packet handshake.
  input  wire logic   pkt_ready,
  output logic        pkt_valid,
  output logic [1:0]  pkt_tag,
  output logic [5:0]  pkt_chan,
  output logic [3:0]  pkt_sync,
  output logic [31:0] pkt_header
);
  initial begin
    {pkt_valid, pkt_tag, pkt_chan, pkt_sync, pkt_header} = '0;
  end

  // Drives at a falling edge, holds through the taking edge, then shows the inverse.
  task automatic send(input logic [43:0] f, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(negedge clk);
    pkt_valid = 1'b1;
    {pkt_tag, pkt_chan, pkt_sync, pkt_header} = f;
    while (ok !== 1'b1 && n < 50) begin
      @(posedge clk);
      ok = pkt_ready;
      n++;
    end
    @(negedge clk);
    pkt_valid = 1'b0;
    {pkt_tag, pkt_chan, pkt_sync, pkt_header} = ~f;
  endtask
endmodule

// file: sim/iso_receive_context_match_tb.sv
`timescale 1ns/100ps

// Random filter settings and packets, scored against a queue model.
module iso_receive_context_match_tb;
  logic        clk, rst_n, reg_wr, reg_rd, reg_rvalid, pkt_valid, pkt_ready, out_valid, out_ready, stall, ok;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, ptr_value, pkt_header, out_header;
  logic [31:0] m [4];
  logic [3:0]  run, soc, amm, ptr_load, pkt_sync;
  logic [7:0]  wsel;
  logic [63:0] cmask;
  logic [6:0]  tsec;
  logic [12:0] tcyc;
  logic [1:0]  pkt_tag, out_ctx;
  logic [5:0]  pkt_chan;
  logic [33:0] q [$];
  int          fails, total_checks;

  irm_match u_dut (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .run(run),
    .start_on_cycle_enable(soc), .all_channels_mask_mode(amm), .wait_select(wsel),
    .channel_mask(cmask), .ptr_load(ptr_load), .ptr_value(ptr_value),
    .timer_seconds_count(tsec), .timer_cycle_count(tcyc), .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready), .pkt_tag(pkt_tag), .pkt_chan(pkt_chan), .pkt_sync(pkt_sync),
    .pkt_header(pkt_header), .out_valid(out_valid), .out_ready(out_ready),
    .out_ctx(out_ctx), .out_header(out_header));
  irm_link u_link (.clk(clk), .pkt_ready(pkt_ready), .pkt_valid(pkt_valid), .pkt_tag(pkt_tag),
    .pkt_chan(pkt_chan), .pkt_sync(pkt_sync), .pkt_header(pkt_header));

  // Clock of 100 ns period.
  always #50 clk = ~clk;

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Register write: one strobe cycle.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // Register read: the answer stands in the cycle after the strobe.
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(34'(reg_rvalid), 34'h1);
    chk(34'(reg_rdata), 34'(e));
  endtask

  // Model: lowest started context whose filters all pass, or -1.
  function automatic int pick(input logic [1:0] t, input logic [5:0] c, input logic [3:0] s);
    logic [31:0] x;
    for (int n = 0; n < 4; n++) begin
      x = m[n];
      if (run[n] && (!soc[n] || {tsec[1:0], tcyc} == x[26:12]) && x[28 + t]
          && !(t == 2'h1 && x[6] && s[3:2] != 2'h0)
          && (amm[n] ? cmask[c] : c == x[5:0])
          && (wsel[2 * n +: 2] != 2'h3 || s == x[11:8]))
        return n;
    end
    return -1;
  endfunction

  // One random packet; expected words are queued before it is offered.
  task automatic send_one();
    logic [43:0] f;
    int          k;
    f = {2'($urandom), 6'($urandom % 4), 4'($urandom % 8), 32'($urandom)};
    k = pick(f[43:42], f[41:36], f[35:32]);
    if (k >= 0) q.push_back({2'(k), f[31:0]});
    u_link.send(f, ok);
    if (ok !== 1'b1) begin
      fails++;
      summarize();
    end
  endtask

  // Bounded wait until every expected word has come out.
  task automatic drain();
    for (int i = 0; i < 100 && q.size() > 0; i++) @(negedge clk);
    chk(34'(q.size()), 34'h0);
    if (q.size() > 0) summarize();
  endtask

  // Receiver stalls at random and scores each popped word.
  always @(negedge clk) out_ready <= !stall && ($urandom % 2 == 0);
  always @(posedge clk) begin
    if (rst_n && out_valid === 1'b1 && out_ready) begin
      if (q.size() == 0) chk(34'h1, 34'h0);
      else chk({out_ctx, out_header}, q.pop_front());
    end
  end

  initial begin
    clk = 1'b0;
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, run, soc, amm, wsel, cmask} = '0;
    {ptr_load, ptr_value, tsec, tcyc, stall, out_ready} = '0;
    void'($urandom(87394));
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    // Reset values, read-zero bits, pointer load and its write protection.
    for (int n = 0; n < 4; n++) begin
      rdchk(16'h040c + 16'(n * 32), 32'h0);
      rdchk(16'h410c + 16'(n * 32), 32'h0);
      wr(16'h410c + 16'(n * 32), 32'hffffffff);
      rdchk(16'h410c + 16'(n * 32), 32'hf7ffff7f);
      ptr_value = $urandom;
      ptr_load = 4'h1 << n;
      @(negedge clk);
      ptr_load = 4'h0;
      wr(16'h040c + 16'(n * 32), ~ptr_value);
      rdchk(16'h040c + 16'(n * 32), ptr_value);
    end
    rdchk(16'h0800, 32'h0);
    // Phases of random settings, then a stall that fills the buffer.
    repeat (10) begin
      run = 4'h0;
      repeat (2) @(negedge clk);
      for (int n = 0; n < 4; n++) begin
        m[n] = $urandom & 32'hf7fff343;
        wr(16'h410c + 16'(n * 32), m[n] | 32'h08000080);
        rdchk(16'h410c + 16'(n * 32), m[n]);
      end
      soc = $urandom;
      amm = $urandom;
      wsel = $urandom;
      cmask = 64'($urandom % 16);
      {tsec, tcyc} = {5'($urandom), m[$urandom % 4][26:12]};
      run = $urandom;
      repeat (3) @(negedge clk);
      repeat (16) send_one();
      drain();
      stall = 1'b1;
      for (int i = 0; i < 40 && q.size() < 2; i++) send_one();
      if (q.size() == 2) chk(34'(pkt_ready), 34'h0);
      stall = 1'b0;
      drain();
    end
    chk(34'(out_valid), 34'h0);
    summarize();
  end
endmodule
